//--- hdl/dbs_pkg.sv
// Package with register selects, field positions and shared types for the debug step block
package dbs_pkg;

	// Debug control register selects
	localparam logic [4:0] DBS_SEL_PATTERN = 5'h0_e;
	localparam logic [4:0] DBS_SEL_MASK    = 5'h0_f;

	// Control bit positions inside the configuration/status word
	localparam int DBS_BIT_NONPIPE = 6;
	localparam int DBS_BIT_IGNINT  = 5;
	localparam int DBS_BIT_STEP    = 4;

	// Extra cycles added per instruction in non-pipelined mode
	localparam int DBS_NONPIPE_EXTRA = 5;

	// Access sizes on the local bus
	typedef enum logic [1:0]
	{
		DBS_SIZE_BYTE = 2'h0,
		DBS_SIZE_WORD = 2'h1,
		DBS_SIZE_LONG = 2'h2
	} dbs_size_t;

	// One register access, from software or from the host
	typedef struct packed
	{
		logic        valid;
		logic        write;
		logic [4:0]  sel;
		logic [31:0] data;
	} dbs_reg_req_t;

	// One operand seen on the local bus
	typedef struct packed
	{
		logic        valid;
		logic [1:0]  addr;
		dbs_size_t   size;
		logic [31:0] data;
	} dbs_bus_op_t;

	// Step sequencer states, Gray along run -> step -> halt
	typedef enum logic [1:0]
	{
		DBS_ST_RUN  = 2'b00,
		DBS_ST_STEP = 2'b01,
		DBS_ST_HALT = 2'b11
	} dbs_state_t;

endpackage

//--- hdl/dbs_data_match.sv
// Masked data comparator with byte-lane placement by address and size
module dbs_data_match
(
	input  wire logic [31:0]        pattern,
	input  wire logic [31:0]        mask,
	input  wire dbs_pkg::dbs_bus_op_t op,
	output logic                     match
);
	import dbs_pkg::*;

	// ==========================================================
	// Lane enables
	wire [3:0] lane_byte;
	wire [3:0] lane_word;
	wire [3:0] lanes;
	wire [31:0] live;

	// Lane 3 is D[31:24], reached by address 00
	assign lane_byte = 4'b1000 >> op.addr;
	assign lane_word = op.addr[1] ? 4'b0011 : 4'b1100;
	assign lanes = (op.size == DBS_SIZE_BYTE) ? lane_byte :
		(op.size == DBS_SIZE_WORD) ? lane_word : 4'b1111;

	// ==========================================================
	// Per-bit compare; a set mask bit or an unused lane always matches
	genvar i;
	generate
		for (i = 0; i < 32; i++)
		begin : g_bit
			assign live[i] = ~mask[i] & lanes[i / 8] &
				(pattern[i] ^ op.data[i]);
		end
	endgenerate

	assign match = op.valid & ~|live;
endmodule

//--- hdl/dbs_reg_file.sv
// Data pattern and mask registers, write from software or host, pattern read by host
module dbs_reg_file
(
	input  wire logic                 clk,
	input  wire dbs_pkg::dbs_reg_req_t sw_req,
	input  wire dbs_pkg::dbs_reg_req_t host_req,
	output logic [31:0]               pattern,
	output logic [31:0]               mask
);
	import dbs_pkg::*;

	// ==========================================================
	// Write decode; host wins a same-cycle clash since it is halting the core
	wire host_wr = host_req.valid & host_req.write;
	wire sw_wr   = sw_req.valid & sw_req.write;
	wire [4:0]  wsel  = host_wr ? host_req.sel : sw_req.sel;
	wire [31:0] wdata = host_wr ? host_req.data : sw_req.data;
	wire any_wr = host_wr | sw_wr;
	wire wr_pat  = any_wr & (wsel == DBS_SEL_PATTERN);
	wire wr_mask = any_wr & (wsel == DBS_SEL_MASK);

	// No reset: contents are undefined until written
	always_ff @(posedge clk)
	begin
		if (wr_pat)
			pattern <= wdata;
		if (wr_mask)
			mask <= wdata;
	end
endmodule

//--- hdl/dbs_debug_step_ctrl.sv
// Debug control: pipeline mode, single-step sequencing and data breakpoint
//
// Summary of operation
// - Non-pipelined bit makes core run one instruction at a time, five extra cycles.
// - Non-pipelined mode disables instruction folding.
// - Program-counter breakpoint always reported before its instruction executes.
// - Pipelined mode may report address or data triggers late.
// - Non-pipelined mode reports address or data triggers before next instruction.
// - Ignore bit masks interrupts pending during single step; clear lets them through.
// - Single-step bit halts the processor after each completed instruction.
// - While halted in single step, any host command is accepted.
// - Each resume in single step runs exactly one instruction then halts.
// - Step-and-halt repeats until the host clears the single-step bit.
// - Comparator checks programmed 32-bit value against local bus data.
// - Only unmasked pattern bits compare; trigger logic qualifies the result.
// - A set mask bit makes that data position always match.
// - Comparison works for aligned and misaligned operands.
// - Operand lane chosen by address and size; byte at 00 is top lane.
// - Pattern register select 0x0E, written by software, read/written by host.
// - Mask register select 0x0F, written by software and host only.
module dbs_debug_step_ctrl
(
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic [2:0]            ctrl_wdata,
	input  wire logic                  ctrl_we,
	input  wire dbs_pkg::dbs_reg_req_t sw_req,
	input  wire dbs_pkg::dbs_reg_req_t host_req,
	input  wire logic                  host_resume,
	input  wire dbs_pkg::dbs_bus_op_t  bus_op,
	input  wire logic                  data_qual_en,
	input  wire logic                  pc_break_hit,
	input  wire logic                  addr_cond_hit,
	input  wire logic                  instr_issue,
	input  wire logic                  instr_done,
	input  wire logic                  irq_pending,
	output logic                       nonpipelined_exec,
	output logic                       ignore_step_interrupts,
	output logic                       single_step_enable,
	output logic                       fold_enable,
	output logic                       issue_hold,
	output logic                       core_halted,
	output logic                       irq_accept,
	output logic                       host_cmd_ready,
	output logic                       host_rd_valid,
	output logic [31:0]                host_rd_data,
	output logic                       pc_trigger,
	output logic                       data_trigger,
	output logic                       data_trigger_precise
);
	import dbs_pkg::*;

	localparam logic [2:0] GAP_LOAD = 3'(DBS_NONPIPE_EXTRA);

	// ==========================================================
	// Control bits of the configuration/status word
	logic       npl_reg;
	logic       ipi_reg;
	logic       ssm_reg;
	logic [2:0] ctrl_next;

	// A write on the control port loads all three control bits; otherwise they keep their value
	assign ctrl_next = ctrl_we ? ctrl_wdata : {npl_reg, ipi_reg, ssm_reg};

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			{npl_reg, ipi_reg, ssm_reg} <= 3'h0;
		else
			{npl_reg, ipi_reg, ssm_reg} <= ctrl_next;
	end

	// ==========================================================
	// Pattern and mask storage
	logic [31:0] pattern;
	logic [31:0] mask;

	dbs_reg_file u_regs
	(
		.clk      (clk),
		.sw_req   (sw_req),
		.host_req (host_req),
		.pattern  (pattern),
		.mask     (mask)
	);

	// ==========================================================
	// Masked data comparator
	logic raw_match;

	dbs_data_match u_match
	(
		.pattern (pattern),
		.mask    (mask),
		.op      (bus_op),
		.match   (raw_match)
	);

	// Trigger logic decides whether the data condition counts
	wire data_hit = raw_match & data_qual_en & addr_cond_hit;

	// ==========================================================
	// Host register read: only the pattern is readable
	wire host_rd  = host_req.valid & ~host_req.write;
	wire rd_pat   = host_rd & (host_req.sel == DBS_SEL_PATTERN);
	wire [31:0] rd_data_next = rd_pat ? pattern : 32'h0000_0000;

	// ==========================================================
	// Single-step sequencer
	dbs_state_t state_reg;
	dbs_state_t state_next;

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			DBS_ST_RUN:
				if (ssm_reg && instr_done)
					state_next = DBS_ST_HALT;
			DBS_ST_STEP:
				if (instr_done)
					state_next = DBS_ST_HALT;
			DBS_ST_HALT:
				if (!ssm_reg)
					state_next = DBS_ST_RUN;
				else if (host_resume)
					state_next = DBS_ST_STEP;
			default:
				state_next = DBS_ST_RUN;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			state_reg <= DBS_ST_RUN;
		else
			state_reg <= state_next;
	end

	// One issue per step: block further issue once the stepped one went out
	logic step_issued_reg;
	wire  step_issued_next = (state_next == DBS_ST_STEP) &
		(step_issued_reg | (state_reg == DBS_ST_STEP & instr_issue));

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			step_issued_reg <= 1'b0;
		else
			step_issued_reg <= step_issued_next;
	end

	// ==========================================================
	// Non-pipelined spacing: hold issue at least five cycles after each completion
	logic [2:0] gap_reg;
	wire  [2:0] gap_next = (npl_reg & instr_done) ? GAP_LOAD :
		(gap_reg != 3'h0) ? gap_reg - 3'h1 : 3'h0;

	// Single outstanding instruction while non-pipelined
	logic busy_reg;
	wire  busy_next = npl_reg & (instr_issue | (busy_reg & ~instr_done));

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			gap_reg  <= 3'h0;
			busy_reg <= 1'b0;
		end
		else
		begin
			gap_reg  <= gap_next;
			busy_reg <= busy_next;
		end
	end

	// ==========================================================
	// Registered outputs
	wire halt_next = (state_next == DBS_ST_HALT);
	wire hold_next = halt_next | step_issued_next |
		(npl_reg & (busy_next | gap_next != 3'h0));
	// Interrupts stay off during a stepped instruction when ignore is set
	wire stepping  = ssm_reg | (state_next != DBS_ST_RUN);
	wire irq_next  = irq_pending & ~halt_next & ~(stepping & ipi_reg);
	// Precise when non-pipelined; the core flags it before the next issue
	wire dtrig_next = data_hit;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			nonpipelined_exec      <= 1'b0;
			ignore_step_interrupts <= 1'b0;
			single_step_enable     <= 1'b0;
			fold_enable            <= 1'b1;
			issue_hold             <= 1'b0;
			core_halted            <= 1'b0;
			irq_accept             <= 1'b0;
			host_cmd_ready         <= 1'b1;
			host_rd_valid          <= 1'b0;
			host_rd_data           <= 32'h0000_0000;
			pc_trigger             <= 1'b0;
			data_trigger           <= 1'b0;
			data_trigger_precise   <= 1'b0;
		end
		else
		begin
			nonpipelined_exec      <= ctrl_next[2];
			ignore_step_interrupts <= ctrl_next[1];
			single_step_enable     <= ctrl_next[0];
			fold_enable            <= ~ctrl_next[2];
			issue_hold             <= hold_next | pc_break_hit;
			core_halted            <= halt_next;
			irq_accept             <= irq_next;
			host_cmd_ready         <= 1'b1;
			host_rd_valid          <= host_rd;
			host_rd_data           <= rd_data_next;
			pc_trigger             <= pc_break_hit;
			data_trigger           <= dtrig_next;
			data_trigger_precise   <= dtrig_next & npl_reg;
		end
	end
endmodule

//--- test/dbs_properties.sv
// Port-level checker for the debug step block, bound to its top module
module dbs_checker
(
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic [2:0] ctrl_wdata,
	input wire logic       ctrl_we,
	input wire logic       host_resume,
	input wire logic       data_qual_en,
	input wire logic       pc_break_hit,
	input wire logic       addr_cond_hit,
	input wire logic       instr_done,
	input wire logic       nonpipelined_exec,
	input wire logic       ignore_step_interrupts,
	input wire logic       single_step_enable,
	input wire logic       fold_enable,
	input wire logic       issue_hold,
	input wire logic       core_halted,
	input wire logic       irq_accept,
	input wire logic       host_cmd_ready,
	input wire logic       pc_trigger,
	input wire logic       data_trigger,
	input wire logic       data_trigger_precise
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// One clock domain, so one default clock and reset
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	AST_FOLD: assert property (fold_enable == !nonpipelined_exec)
		else $error("folding allowed in non-pipelined mode");
	AST_CTRL: assert property (ctrl_we |=>
		{nonpipelined_exec, ignore_step_interrupts, single_step_enable} == $past(ctrl_wdata))
		else $error("control bits not taken");
	AST_NPHOLD: assert property (nonpipelined_exec && instr_done |=> issue_hold[*5])
		else $error("issue released too soon");
	AST_HALT: assert property (single_step_enable && instr_done |=> core_halted)
		else $error("no halt after step");
	AST_RESUME: assert property (core_halted && host_resume |=> !core_halted)
		else $error("resume ignored");
	AST_HOLD: assert property (core_halted && $past(core_halted) |-> issue_hold)
		else $error("issue while halted");
	AST_IRQ: assert property (core_halted && $past(core_halted) |-> !irq_accept)
		else $error("interrupt taken while halted");
	AST_RDY: assert property (host_cmd_ready)
		else $error("host command refused");
	AST_PC: assert property (pc_break_hit |=> pc_trigger)
		else $error("pc trigger late");
	AST_DTRIG: assert property (data_trigger |-> $past(data_qual_en && addr_cond_hit))
		else $error("unqualified data trigger");
	AST_PREC: assert property (data_trigger_precise |-> data_trigger)
		else $error("precise flag alone");
endmodule
bind dbs_debug_step_ctrl dbs_checker u_dbs_checker (.*);

//--- test/dbs_host_model.sv
// Debug host model: register commands and resume over the debug port
module dbs_host_model
(
	input wire logic               clk,
	input wire logic               host_cmd_ready,
	input wire logic               host_rd_valid,
	input wire logic [31:0]        host_rd_data,
	output dbs_pkg::dbs_reg_req_t  host_req,
	output logic                   host_resume
);
	timeunit 1ns;
	timeprecision 1ps;
	import dbs_pkg::*;
	// ==========
	// Idle until the bench asks for a command
	initial
	begin
		host_req = '0;
		host_resume = 1'b0;
	end
	// One command held across one rising edge; the read answer stands one cycle only,
	// so it is taken before release, and all ones means no valid answer came
	task automatic cmd(input logic wr, input logic [4:0] sel, input logic [31:0] d,
		output logic [31:0] q);
		@(negedge clk);
		wait (host_cmd_ready);
		host_req = '{1'b1, wr, sel, d};
		@(negedge clk);
		q = host_rd_valid ? host_rd_data : 32'hFFFF_FFFF;
		host_req.valid = 1'b0;
		host_req.data = ~d;
		@(negedge clk);
	endtask
	// Go pulse; each one lets a single instruction through
	task automatic resume();
		@(negedge clk);
		host_resume = 1'b1;
		@(negedge clk);
		host_resume = 1'b0;
	endtask
endmodule

//--- test/tb.sv
// Self-checking bench for the debug step block
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import dbs_pkg::*;
	logic clk, rst_n, ctrl_we, host_resume, data_qual_en, pc_break_hit, addr_cond_hit;
	logic instr_issue, instr_done, irq_pending, np, ig, ss, fold, hold, halted, irq_ok;
	logic rdy, rd_v, pc_t, d_t, d_p;
	logic [2:0] ctrl_wdata;
	logic [31:0] rd_d, q;
	dbs_reg_req_t sw_req, host_req;
	dbs_bus_op_t bus_op;
	int error_cnt = 0;
	int checked = 0;
	// ==========
	// 250 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	dbs_debug_step_ctrl u_dbs_debug_step_ctrl (.clk(clk), .rst_n(rst_n),
		.ctrl_wdata(ctrl_wdata), .ctrl_we(ctrl_we), .sw_req(sw_req), .host_req(host_req),
		.host_resume(host_resume), .bus_op(bus_op), .data_qual_en(data_qual_en),
		.pc_break_hit(pc_break_hit), .addr_cond_hit(addr_cond_hit), .instr_issue(instr_issue),
		.instr_done(instr_done), .irq_pending(irq_pending), .nonpipelined_exec(np),
		.ignore_step_interrupts(ig), .single_step_enable(ss), .fold_enable(fold),
		.issue_hold(hold), .core_halted(halted), .irq_accept(irq_ok), .host_cmd_ready(rdy),
		.host_rd_valid(rd_v), .host_rd_data(rd_d), .pc_trigger(pc_t), .data_trigger(d_t),
		.data_trigger_precise(d_p));
	dbs_host_model u_dbs_host_model (.clk(clk), .host_cmd_ready(rdy), .host_rd_valid(rd_v),
		.host_rd_data(rd_d), .host_req(host_req), .host_resume(host_resume));
	// ==========
	// Shared helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic ctl(input logic [2:0] v);
		ctrl_wdata = v;
		ctrl_we = 1'b1;
		cyc(1);
		ctrl_we = 1'b0;
	endtask
	task automatic swr(input logic [4:0] s, input logic [31:0] d);
		sw_req = '{1'b1, 1'b1, s, d};
		cyc(1);
		sw_req = '0;
	endtask
	task automatic inst();
		instr_issue = 1'b1;
		cyc(1);
		instr_issue = 1'b0;
		instr_done = 1'b1;
		cyc(1);
		instr_done = 1'b0;
		cyc(1);
	endtask
	// Operand on the bus, trigger and precise flag judged one cycle later
	task automatic op(input logic [1:0] a, input dbs_size_t s, input logic [31:0] d,
		input logic e);
		bus_op = '{1'b1, a, s, d};
		cyc(1);
		chk({d_t, d_p}, {e, e & np});
		bus_op.valid = 1'b0;
		cyc(1);
	endtask
	// ==========
	// Scenarios
	task automatic t_regs();
		u_dbs_host_model.cmd(1'b1, DBS_SEL_PATTERN, 32'hA5A5_0F0F, q);
		u_dbs_host_model.cmd(1'b0, DBS_SEL_PATTERN, 32'h0000_0000, q);
		chk(q, 32'hA5A5_0F0F);
		swr(DBS_SEL_PATTERN, 32'h1122_3344);
		u_dbs_host_model.cmd(1'b0, DBS_SEL_PATTERN, 32'h0000_0000, q);
		chk(q, 32'h1122_3344);
		u_dbs_host_model.cmd(1'b1, DBS_SEL_MASK, 32'hFFFF_0000, q);
		u_dbs_host_model.cmd(1'b0, DBS_SEL_MASK, 32'h0000_0000, q);
		chk(q, 32'h0000_0000);
		$display("t_regs done");
	endtask
	task automatic t_match();
		swr(DBS_SEL_MASK, 32'h0000_0000);
		op(2'h0, DBS_SIZE_LONG, 32'h1122_3344, 1'b1);
		op(2'h0, DBS_SIZE_LONG, 32'h1122_3345, 1'b0);
		op(2'h0, DBS_SIZE_BYTE, 32'h11EE_EEEE, 1'b1);
		op(2'h0, DBS_SIZE_BYTE, 32'h10EE_EEEE, 1'b0);
		op(2'h1, DBS_SIZE_BYTE, 32'hEE22_EEEE, 1'b1);
		op(2'h2, DBS_SIZE_BYTE, 32'hEEEE_33EE, 1'b1);
		op(2'h3, DBS_SIZE_BYTE, 32'hEEEE_EE44, 1'b1);
		op(2'h1, DBS_SIZE_WORD, 32'h1122_EEEE, 1'b1);
		op(2'h2, DBS_SIZE_WORD, 32'hEEEE_3345, 1'b0);
		swr(DBS_SEL_MASK, 32'h0000_00FF);
		op(2'h0, DBS_SIZE_LONG, 32'h1122_33AA, 1'b1);
		data_qual_en = 1'b0;
		op(2'h0, DBS_SIZE_LONG, 32'h1122_3344, 1'b0);
		data_qual_en = 1'b1;
		ctl(3'b100);
		op(2'h0, DBS_SIZE_LONG, 32'h1122_3344, 1'b1);
		ctl(3'b000);
		$display("t_match done");
	endtask
	task automatic t_step();
		irq_pending = 1'b1;
		ctl(3'b011);
		cyc(2);
		chk({ig, ss, irq_ok}, 3'b110);
		ctl(3'b001);
		cyc(2);
		chk(irq_ok, 1'b1);
		inst();
		chk({halted, hold, irq_ok}, 3'b110);
		u_dbs_host_model.cmd(1'b0, DBS_SEL_PATTERN, 32'h0000_0000, q);
		chk(q, 32'h1122_3344);
		repeat (2)
		begin
			u_dbs_host_model.resume();
			chk(halted, 1'b0);
			inst();
			chk(halted, 1'b1);
		end
		ctl(3'b000);
		cyc(2);
		chk({halted, irq_ok}, 2'b01);
		irq_pending = 1'b0;
		$display("t_step done");
	endtask
	task automatic t_pipe();
		ctl(3'b100);
		chk({np, fold}, 2'b10);
		inst();
		// Hold stands five cycles after completion, then must drop
		cyc(3);
		chk(hold, 1'b1);
		cyc(1);
		chk(hold, 1'b0);
		pc_break_hit = 1'b1;
		cyc(1);
		pc_break_hit = 1'b0;
		chk({pc_t, hold}, 2'b11);
		ctl(3'b000);
		chk(fold, 1'b1);
		$display("t_pipe done");
	endtask
	task automatic test_done();
		$display("checked=%0d error_cnt=%0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ==========
	// Watchdog, well past the hundred or so cycles the tests need
	initial
	begin
		cyc(5000);
		error_cnt++;
		test_done();
	end
	// Main sequence
	initial
	begin
		{rst_n, ctrl_we, data_qual_en, pc_break_hit, instr_issue, instr_done} = '0;
		{irq_pending, ctrl_wdata} = '0;
		addr_cond_hit = 1'b1;
		data_qual_en = 1'b1;
		sw_req = '0;
		bus_op = '0;
		cyc(20);
		rst_n = 1'b1;
		chk({fold, rdy, halted, hold}, 4'b1100);
		t_regs();
		t_match();
		t_step();
		t_pipe();
		test_done();
	end
endmodule
